/* File: hw/usbtr_pkg.sv */
// Summary of operation
// - endpoint zero takes control transactions only
// - host starts everything; device only answers tokens and data packets
// - bulk uses token, data, handshake and retry
// - bulk IN with data sends DATA0/DATA1
// - IN without data gets NAK, no data; isochronous IN gets an empty DATA0
// - halted endpoint answers STALL
// - host gives no handshake on bad data
// - good bulk OUT data is accepted, ACKed
// - busy OUT or SETUP answers NAK after data
// - bad host data gets no handshake
// - isochronous data kept even when corrupted
// - isochronous is token plus DATA0, no handshake
// - isochronous at most 90 percent, every frame
// - intact SETUP data ACKed, corrupted gets silence
// - setup uses DATA0, data stage starts DATA1
// - control write uses OUT, read uses IN
// - status stage runs opposite the data stage
// - status stage always carries DATA1
// - interrupt starts DATA0; IN, data, ACK
// - payload limits 8, 64, 256 bytes
package usbtr_pkg;
   // ****************
   // packet ids
   // ****************
   localparam logic [3:0] PID_OUT = 4'h1;
   localparam logic [3:0] PID_IN = 4'h9;
   localparam logic [3:0] PID_SOF = 4'h5;
   localparam logic [3:0] PID_SETUP = 4'hD;
   localparam logic [3:0] PID_DATA0 = 4'h3;
   localparam logic [3:0] PID_DATA1 = 4'hB;
   localparam logic [3:0] PID_ACK = 4'h2;
   localparam logic [3:0] PID_NAK = 4'hA;
   localparam logic [3:0] PID_STALL = 4'hE;
   // ****************
   // endpoints and sizes
   // ****************
   typedef enum logic [1:0] {
      EP_CTRL = 2'b00,
      EP_ISO = 2'b01,
      EP_BULK = 2'b10,
      EP_INTR = 2'b11
   } usbtr_ep_t;
   localparam logic [31:0] EP_TYPES_DEF = 32'hAAAA_AAB4;
   localparam logic [8:0] MAX_INTR = 9'h008;
   localparam logic [8:0] MAX_BULK = 9'h040;
   localparam logic [8:0] MAX_ISO = 9'h100;
   localparam logic [8:0] MAX_CTRL = 9'h040;
   localparam int CTL_DIR_BIT = 7;
   localparam int FIFO_DEPTH = 16;
   localparam int FIFO_W = 13;
   // ****************
   // timing
   // ****************
   localparam int CLK_PERIOD_NS = 5;
   localparam int RESP_TO_NS = 1500;
   localparam logic [15:0] RESP_TO_CYC = 16'(RESP_TO_NS / CLK_PERIOD_NS);
   localparam int FRAME_NS = 1000000;
   localparam int FRAME_CYC_DEF = FRAME_NS / CLK_PERIOD_NS;
   localparam int ISO_PCT = 90;
   typedef enum logic [2:0] {
      RES_ACK = 3'b000,
      RES_NAK = 3'b001,
      RES_STALL = 3'b010,
      RES_NONE = 3'b011,
      RES_DATA = 3'b100
   } usbtr_res_t;
   // ****************
   // helpers
   // ****************
   function automatic usbtr_ep_t ep_type(input logic [31:0] map,
                                         input logic [3:0] ep);
      usbtr_ep_t t;
      t = usbtr_ep_t'(map[{ep, 1'b0} +: 2]);
      if (ep == 4'h0) begin
         t = EP_CTRL;
      end else if (t == EP_CTRL) begin
         t = EP_BULK;
      end
      return t;
   endfunction
   function automatic logic [8:0] max_len(input usbtr_ep_t t);
      case (t)
         EP_INTR: return MAX_INTR;
         EP_BULK: return MAX_BULK;
         EP_ISO: return MAX_ISO;
         default: return MAX_CTRL;
      endcase
   endfunction
   function automatic logic [3:0] data_pid(input logic tog);
      return tog ? PID_DATA1 : PID_DATA0;
   endfunction
   function automatic logic is_data(input logic [3:0] pid);
      return (pid == PID_DATA0) || (pid == PID_DATA1);
   endfunction
endpackage

/* File: hw/usbtr_link_if.sv */
`timescale 1ns/10ps
`default_nettype none
interface usbtr_link_if;
   // host to device beats
   logic h_vld;
   logic [3:0] h_pid;
   logic [3:0] h_ep;
   logic [7:0] h_byte;
   logic h_dat;
   logic h_end;
   logic h_err;
   // device to host beats
   logic d_vld;
   logic [3:0] d_pid;
   logic [7:0] d_byte;
   logic d_dat;
   logic d_end;
   logic d_err;
   modport dev (
      input h_vld, h_pid, h_ep, h_byte, h_dat, h_end, h_err,
      output d_vld, d_pid, d_byte, d_dat, d_end, d_err
   );
   modport host (
      output h_vld, h_pid, h_ep, h_byte, h_dat, h_end, h_err,
      input d_vld, d_pid, d_byte, d_dat, d_end, d_err
   );
endinterface
`default_nettype wire

/* File: hw/usbtr_fifo.sv */
`timescale 1ns/10ps
`default_nettype none
module usbtr_fifo #(
   parameter int W = 13,
   parameter int DEPTH = 16
) (
   // clock and reset
   input wire logic clk,
   input wire logic arst_n,
   input wire logic ce,
   // fill side
   input wire logic in_valid,
   output logic in_ready,
   input wire logic [W-1:0] in_data,
   // drain side
   output logic out_valid,
   input wire logic out_ready,
   output logic [W-1:0] out_data
);
   localparam int AW = $clog2(DEPTH);
   localparam logic [AW:0] DEPTH_C = (AW+1)'(DEPTH);
   typedef struct packed {
      logic [AW-1:0] wp;
      logic [AW-1:0] rp;
      logic [AW:0] cnt;
      logic full;
      logic empty;
   } usbtr_fifo_s_t;
   usbtr_fifo_s_t s, n;
   logic [W-1:0] mem [DEPTH];
   logic push, pop;

   always_comb begin
      n = s;
      push = in_valid && !s.full;
      pop = out_ready && !s.empty;
      if (push) begin
         n.wp = (s.wp == AW'(DEPTH-1)) ? '0 : s.wp + AW'(1);
      end
      if (pop) begin
         n.rp = (s.rp == AW'(DEPTH-1)) ? '0 : s.rp + AW'(1);
      end
      n.cnt = s.cnt + (AW+1)'(push) - (AW+1)'(pop);
      // registered flags keep both ready and valid glitch free
      n.full = (n.cnt == DEPTH_C);
      n.empty = (n.cnt == '0);
   end

   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         s <= '{wp: '0, rp: '0, cnt: '0, full: 1'b0, empty: 1'b1};
      end else if (ce) begin
         s <= n;
      end
   end

   always_ff @(posedge clk) begin
      if (ce && push) begin
         mem[s.wp] <= in_data;
      end
   end

   assign in_ready = !s.full;
   assign out_valid = !s.empty;
   assign out_data = mem[s.rp];
endmodule
`default_nettype wire

/* File: hw/usbtr_device.sv */
`timescale 1ns/10ps
`default_nettype none
module usbtr_device #(
   parameter logic [31:0] EP_TYPES = usbtr_pkg::EP_TYPES_DEF,
   parameter int FIFO_DEPTH = usbtr_pkg::FIFO_DEPTH
) (
   // clock and reset
   input wire logic clk,
   input wire logic arst_n,
   input wire logic ce,
   // link
   usbtr_link_if.dev lnk,
   // in data from user
   input wire logic tx_valid,
   output logic tx_ready,
   input wire logic [7:0] tx_data,
   input wire logic tx_last,
   input wire logic [3:0] tx_ep,
   input wire logic inj_err,
   // endpoint control
   input wire logic [15:0] halt,
   // out data to user
   input wire logic rx_ready,
   output logic rx_valid,
   output logic [7:0] rx_byte,
   output logic rx_end,
   output logic rx_bad,
   output logic [3:0] rx_ep,
   output logic rx_setup
);
   // ****************
   // state
   // ****************
   typedef enum logic [1:0] {
      D_IDLE = 2'b00,
      D_RX = 2'b01,
      D_TX = 2'b10,
      D_WAIT = 2'b11
   } usbtr_dst_t;
   typedef struct packed {
      usbtr_dst_t st;
      logic [3:0] ep;
      logic setup;
      logic acc;
      logic dup;
      logic first;
      logic zlp;
      logic iso;
      logic [3:0] dpid;
      logic [8:0] idx;
      logic [15:0] tmr;
      logic [8:0] ld_cnt;
      logic [8:0] buf_len;
      logic buf_full;
      logic [3:0] buf_ep;
      logic [15:0] tog_in;
      logic [15:0] tog_out;
      logic ctl_rd;
      logic d_vld;
      logic [3:0] d_pid;
      logic [7:0] d_byte;
      logic d_dat;
      logic d_end;
      logic d_err;
      logic rx_valid;
      logic [7:0] rx_byte;
      logic rx_end;
      logic rx_bad;
      logic [3:0] rx_ep;
      logic rx_setup;
   } usbtr_dev_s_t;
   usbtr_dev_s_t s, n;
   logic [7:0] mem [256];
   logic f_valid, f_ready, f_last;
   logic [7:0] f_byte;
   logic [3:0] f_ep;
   logic wr_en, hs_go, dup_now, fwd, tx_end;
   logic [3:0] hs_pid;
   usbtr_pkg::usbtr_ep_t ept;

   // ****************
   // in data queue
   // ****************
   usbtr_fifo #(
      .W(usbtr_pkg::FIFO_W),
      .DEPTH(FIFO_DEPTH)
   ) u_fifo (
      .clk(clk),
      .arst_n(arst_n),
      .ce(ce),
      .in_valid(tx_valid),
      .in_ready(tx_ready),
      .in_data({tx_ep, tx_last, tx_data}),
      .out_valid(f_valid),
      .out_ready(f_ready),
      .out_data({f_ep, f_last, f_byte})
   );

   // ****************
   // sequencer
   // ****************
   always_comb begin
      n = s;
      ept = usbtr_pkg::ep_type(EP_TYPES, lnk.h_ep);
      n.d_vld = 1'b0;
      n.d_dat = 1'b0;
      n.d_end = 1'b0;
      n.d_err = 1'b0;
      n.rx_valid = 1'b0;
      n.rx_end = 1'b0;
      hs_go = 1'b0;
      hs_pid = usbtr_pkg::PID_NAK;
      f_ready = 1'b0;
      wr_en = 1'b0;
      dup_now = s.dup;
      fwd = 1'b0;
      tx_end = 1'b0;
      // retry buffer fills only while not full, so a resend sees the same bytes
      if (!s.buf_full && f_valid) begin
         f_ready = 1'b1;
         wr_en = 1'b1;
         n.ld_cnt = s.ld_cnt + 9'h001;
         if (f_last || n.ld_cnt ==
             usbtr_pkg::max_len(usbtr_pkg::ep_type(EP_TYPES, f_ep))) begin
            n.buf_full = 1'b1;
            n.buf_len = n.ld_cnt;
            n.buf_ep = f_ep;
            n.ld_cnt = 9'h000;
         end
      end
      case (s.st)
         D_IDLE: begin
            if (lnk.h_vld && !lnk.h_err) begin
               n.ep = lnk.h_ep;
               n.iso = (ept == usbtr_pkg::EP_ISO);
               n.first = 1'b1;
               n.idx = 9'h000;
               n.tmr = 16'h0000;
               n.zlp = 1'b0;
               case (lnk.h_pid)
                  usbtr_pkg::PID_IN: begin
                     if (halt[lnk.h_ep]) begin
                        hs_go = 1'b1;
                        hs_pid = usbtr_pkg::PID_STALL;
                     end else if (ept == usbtr_pkg::EP_CTRL && !s.ctl_rd) begin
                        n.zlp = 1'b1;
                        n.dpid = usbtr_pkg::PID_DATA1;
                        n.st = D_TX;
                     end else if (s.buf_full && s.buf_ep == lnk.h_ep) begin
                        n.dpid = (ept == usbtr_pkg::EP_ISO) ?
                           usbtr_pkg::PID_DATA0 :
                           usbtr_pkg::data_pid(s.tog_in[lnk.h_ep]);
                        n.st = D_TX;
                     end else if (ept == usbtr_pkg::EP_ISO) begin
                        // nothing queued: an empty DATA0 keeps the slot
                        n.zlp = 1'b1;
                        n.dpid = usbtr_pkg::PID_DATA0;
                        n.st = D_TX;
                     end else begin
                        hs_go = 1'b1;
                        hs_pid = usbtr_pkg::PID_NAK;
                     end
                  end
                  usbtr_pkg::PID_OUT, usbtr_pkg::PID_SETUP: begin
                     if (lnk.h_pid == usbtr_pkg::PID_OUT ||
                         ept == usbtr_pkg::EP_CTRL) begin
                        n.setup = (lnk.h_pid == usbtr_pkg::PID_SETUP);
                        n.acc = rx_ready && !halt[lnk.h_ep];
                        n.st = D_RX;
                     end
                  end
                  default: begin
                  end
               endcase
            end
         end
         D_RX: begin
            if (lnk.h_vld) begin
               n.first = 1'b0;
               if (s.first) begin
                  // same toggle as last accepted packet means a retry
                  dup_now = !s.iso && !s.setup &&
                     lnk.h_pid == usbtr_pkg::data_pid(!s.tog_out[s.ep]);
                  n.dup = dup_now;
                  if (s.setup && lnk.h_dat) begin
                     n.ctl_rd = lnk.h_byte[usbtr_pkg::CTL_DIR_BIT];
                  end
               end
               fwd = s.acc && !dup_now;
               n.rx_valid = fwd && lnk.h_dat;
               n.rx_byte = lnk.h_byte;
               n.rx_ep = s.ep;
               n.rx_setup = s.setup;
               if (s.first && !usbtr_pkg::is_data(lnk.h_pid)) begin
                  n.st = D_IDLE;
                  n.rx_valid = 1'b0;
               end else if (lnk.h_end) begin
                  n.st = D_IDLE;
                  n.rx_end = fwd;
                  n.rx_bad = lnk.h_err;
                  if (s.iso || lnk.h_err) begin
                     hs_go = 1'b0;
                  end else if (halt[s.ep]) begin
                     hs_go = 1'b1;
                     hs_pid = usbtr_pkg::PID_STALL;
                  end else if (!s.acc) begin
                     hs_go = 1'b1;
                     hs_pid = usbtr_pkg::PID_NAK;
                  end else begin
                     hs_go = 1'b1;
                     hs_pid = usbtr_pkg::PID_ACK;
                     if (s.setup) begin
                        n.tog_out[0] = 1'b1;
                        n.tog_in[0] = 1'b1;
                     end else if (!dup_now) begin
                        n.tog_out[s.ep] = !s.tog_out[s.ep];
                     end
                  end
               end
            end
         end
         D_TX: begin
            tx_end = s.zlp || (s.idx + 9'h001 == s.buf_len);
            n.d_vld = 1'b1;
            n.d_pid = s.dpid;
            n.d_byte = mem[s.idx[7:0]];
            n.d_dat = !s.zlp;
            n.d_end = tx_end;
            n.idx = s.idx + 9'h001;
            if (tx_end) begin
               n.d_err = inj_err;
               n.tmr = 16'h0000;
               if (s.iso) begin
                  n.st = D_IDLE;
                  // keep a packet that the loader closes in this cycle
                  n.buf_full = n.buf_full && s.zlp;
               end else begin
                  n.st = D_WAIT;
               end
            end
         end
         D_WAIT: begin
            n.tmr = s.tmr + 16'h0001;
            if (lnk.h_vld) begin
               n.st = D_IDLE;
               if (lnk.h_pid == usbtr_pkg::PID_ACK && !s.zlp) begin
                  n.buf_full = 1'b0;
                  n.tog_in[s.ep] = !s.tog_in[s.ep];
               end
            end else if (s.tmr == usbtr_pkg::RESP_TO_CYC) begin
               n.st = D_IDLE;
            end
         end
         default: begin
            n.st = D_IDLE;
         end
      endcase
      if (hs_go) begin
         n.d_vld = 1'b1;
         n.d_pid = hs_pid;
         n.d_end = 1'b1;
      end
   end

   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         s <= '0;
      end else if (ce) begin
         s <= n;
      end
   end

   always_ff @(posedge clk) begin
      if (ce && wr_en) begin
         mem[s.ld_cnt[7:0]] <= f_byte;
      end
   end

   // ****************
   // outputs
   // ****************
   assign lnk.d_vld = s.d_vld;
   assign lnk.d_pid = s.d_pid;
   assign lnk.d_byte = s.d_byte;
   assign lnk.d_dat = s.d_dat;
   assign lnk.d_end = s.d_end;
   assign lnk.d_err = s.d_err;
   assign rx_valid = s.rx_valid;
   assign rx_byte = s.rx_byte;
   assign rx_end = s.rx_end;
   assign rx_bad = s.rx_bad;
   assign rx_ep = s.rx_ep;
   assign rx_setup = s.rx_setup;
endmodule
`default_nettype wire

/* File: hw/usbtr_host.sv */
`timescale 1ns/10ps
`default_nettype none
module usbtr_host #(
   parameter int FRAME_CYC = usbtr_pkg::FRAME_CYC_DEF
) (
   // clock and reset
   input wire logic clk,
   input wire logic arst_n,
   input wire logic ce,
   // link
   usbtr_link_if.host lnk,
   // commands
   input wire logic cmd_valid,
   output logic cmd_ready,
   input wire logic [3:0] cmd_pid,
   input wire logic [3:0] cmd_ep,
   input wire logic cmd_tog,
   input wire logic [8:0] cmd_len,
   input wire logic [7:0] cmd_seed,
   input wire logic cmd_corrupt,
   input wire logic cmd_iso,
   output logic iso_full,
   // results
   output logic res_valid,
   output logic [2:0] res_code,
   output logic res_tog,
   output logic [8:0] res_len,
   output logic res_bad,
   output logic in_valid,
   output logic [7:0] in_byte
);
   localparam logic [31:0] ISO_BUDGET = 32'(FRAME_CYC / 100 * usbtr_pkg::ISO_PCT);
   localparam logic [31:0] FRAME_LAST = 32'(FRAME_CYC - 1);
   typedef enum logic [1:0] {
      H_IDLE = 2'b00,
      H_DATA = 2'b01,
      H_WAIT = 2'b10
   } usbtr_hst_t;
   typedef struct packed {
      usbtr_hst_t st;
      logic [3:0] pid;
      logic tog;
      logic [8:0] len;
      logic [7:0] seed;
      logic corrupt;
      logic iso;
      logic [8:0] idx;
      logic [15:0] tmr;
      logic [31:0] frm;
      logic [31:0] iso_used;
      logic sof_pend;
      logic iso_full;
      logic cmd_ready;
      logic h_vld;
      logic [3:0] h_pid;
      logic [3:0] h_ep;
      logic [7:0] h_byte;
      logic h_dat;
      logic h_end;
      logic h_err;
      logic res_valid;
      usbtr_pkg::usbtr_res_t res_code;
      logic res_tog;
      logic [8:0] res_len;
      logic res_bad;
      logic in_valid;
      logic [7:0] in_byte;
   } usbtr_host_s_t;
   usbtr_host_s_t s, n;
   logic last;

   always_comb begin
      n = s;
      n.h_vld = 1'b0;
      n.h_dat = 1'b0;
      n.h_end = 1'b0;
      n.h_err = 1'b0;
      n.res_valid = 1'b0;
      n.in_valid = 1'b0;
      last = (s.len == 9'h000) || (s.idx + 9'h001 == s.len);
      // ****************
      // frame pacing
      // ****************
      n.frm = s.frm + 32'h0000_0001;
      if (s.st != H_IDLE && s.iso) begin
         n.iso_used = s.iso_used + 32'h0000_0001;
      end
      if (s.frm == FRAME_LAST) begin
         n.frm = 32'h0000_0000;
         n.iso_used = 32'h0000_0000;
         n.sof_pend = 1'b1;
      end
      n.iso_full = (n.iso_used >= ISO_BUDGET);
      case (s.st)
         H_IDLE: begin
            if (s.sof_pend) begin
               n.sof_pend = 1'b0;
               n.h_vld = 1'b1;
               n.h_pid = usbtr_pkg::PID_SOF;
               n.h_ep = 4'h0;
               n.h_end = 1'b1;
            end else if (cmd_valid && s.cmd_ready &&
                         !(cmd_iso && s.iso_full)) begin
               n.h_vld = 1'b1;
               n.h_pid = cmd_pid;
               n.h_ep = cmd_ep;
               n.h_end = 1'b1;
               n.pid = cmd_pid;
               n.tog = cmd_tog && !cmd_iso;
               n.len = cmd_len;
               n.seed = cmd_seed;
               n.corrupt = cmd_corrupt;
               n.iso = cmd_iso;
               n.idx = 9'h000;
               n.tmr = 16'h0000;
               n.st = (cmd_pid == usbtr_pkg::PID_IN) ? H_WAIT : H_DATA;
            end
         end
         H_DATA: begin
            n.h_vld = 1'b1;
            n.h_pid = usbtr_pkg::data_pid(s.tog);
            n.h_byte = s.seed + s.idx[7:0];
            n.h_dat = (s.len != 9'h000);
            n.h_end = last;
            n.h_err = last && s.corrupt;
            n.idx = s.idx + 9'h001;
            if (last) begin
               n.tmr = 16'h0000;
               n.idx = 9'h000;
               if (s.iso) begin
                  n.st = H_IDLE;
                  n.res_valid = 1'b1;
                  n.res_code = usbtr_pkg::RES_NONE;
               end else begin
                  n.st = H_WAIT;
               end
            end
         end
         H_WAIT: begin
            n.tmr = s.tmr + 16'h0001;
            if (lnk.d_vld) begin
               n.tmr = 16'h0000;
               if (usbtr_pkg::is_data(lnk.d_pid)) begin
                  n.in_valid = lnk.d_dat;
                  n.in_byte = lnk.d_byte;
                  n.idx = s.idx + 9'(lnk.d_dat);
                  if (lnk.d_end) begin
                     n.st = H_IDLE;
                     n.res_valid = 1'b1;
                     n.res_code = usbtr_pkg::RES_DATA;
                     n.res_tog = (lnk.d_pid == usbtr_pkg::PID_DATA1);
                     n.res_len = n.idx;
                     n.res_bad = lnk.d_err;
                     // silence on bad data lets the device resend
                     if (!lnk.d_err && !s.iso) begin
                        n.h_vld = 1'b1;
                        n.h_pid = usbtr_pkg::PID_ACK;
                        n.h_end = 1'b1;
                     end
                  end
               end else if (lnk.d_end) begin
                  n.st = H_IDLE;
                  n.res_valid = 1'b1;
                  n.res_bad = 1'b0;
                  case (lnk.d_pid)
                     usbtr_pkg::PID_ACK: n.res_code = usbtr_pkg::RES_ACK;
                     usbtr_pkg::PID_NAK: n.res_code = usbtr_pkg::RES_NAK;
                     usbtr_pkg::PID_STALL: n.res_code = usbtr_pkg::RES_STALL;
                     default: n.res_code = usbtr_pkg::RES_NONE;
                  endcase
               end
            end else if (s.tmr == usbtr_pkg::RESP_TO_CYC) begin
               n.st = H_IDLE;
               n.res_valid = 1'b1;
               n.res_code = usbtr_pkg::RES_NONE;
            end
         end
         default: begin
            n.st = H_IDLE;
         end
      endcase
      n.cmd_ready = (n.st == H_IDLE) && !n.sof_pend && !n.h_vld;
   end

   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         s <= '0;
      end else if (ce) begin
         s <= n;
      end
   end

   // ****************
   // outputs
   // ****************
   assign lnk.h_vld = s.h_vld;
   assign lnk.h_pid = s.h_pid;
   assign lnk.h_ep = s.h_ep;
   assign lnk.h_byte = s.h_byte;
   assign lnk.h_dat = s.h_dat;
   assign lnk.h_end = s.h_end;
   assign lnk.h_err = s.h_err;
   assign cmd_ready = s.cmd_ready;
   assign iso_full = s.iso_full;
   assign res_valid = s.res_valid;
   assign res_code = s.res_code;
   assign res_tog = s.res_tog;
   assign res_len = s.res_len;
   assign res_bad = s.res_bad;
   assign in_valid = s.in_valid;
   assign in_byte = s.in_byte;
endmodule
`default_nettype wire

/* File: testbench/usbtr_link_assertions.sv */
`timescale 1ns/10ps
`default_nettype none
module usbtr_link_assertions (
   // clock and reset
   input wire logic clk,
   input wire logic arst_n,
   // link beats
   input wire logic h_vld,
   input wire logic [3:0] h_pid,
   input wire logic [3:0] h_ep,
   input wire logic h_end,
   input wire logic h_err,
   input wire logic d_vld,
   input wire logic [3:0] d_pid,
   input wire logic d_dat,
   input wire logic d_end,
   input wire logic d_err
);
   default clocking @(posedge clk); endclocking
   default disable iff (!arst_n);
   sequence s_tok_in; h_vld && h_pid == usbtr_pkg::PID_IN; endsequence
   sequence s_setup; h_vld && h_pid == usbtr_pkg::PID_SETUP; endsequence
   property p_speak;
      $rose(d_vld) |-> $past(h_vld && h_end) ||
         $past(h_vld && h_pid == usbtr_pkg::PID_IN, 2);
   endproperty
   a_speak: assert property (p_speak) else $error("stray beat");
   property p_nak;
      d_vld && d_pid == usbtr_pkg::PID_NAK |-> d_end && !d_dat;
   endproperty
   a_nak: assert property (p_nak) else $error("nak carries data");
   property p_ack;
      h_vld && h_pid == usbtr_pkg::PID_ACK |-> $past(d_end && !d_err);
   endproperty
   a_ack: assert property (p_ack) else $error("stray ack");
   property p_bad_out; h_vld && h_end && h_err |=> !d_vld; endproperty
   a_bad_out: assert property (p_bad_out) else $error("answered");
   property p_bad_in; d_vld && d_end && d_err |=> !h_vld [*2]; endproperty
   a_bad_in: assert property (p_bad_in) else $error("host answered");
   property p_in; s_tok_in |-> ##[1:2] d_vld; endproperty
   a_in: assert property (p_in) else $error("in unanswered");
   property p_iso;
      s_tok_in ##0 h_ep == 4'h1 ##1 !d_vld |=>
         d_vld && d_pid == usbtr_pkg::PID_DATA0;
   endproperty
   a_iso: assert property (p_iso) else $error("iso not data0");
   property p_setup; s_setup |=> h_pid == usbtr_pkg::PID_DATA0; endproperty
   a_setup: assert property (p_setup) else $error("setup data");
endmodule
`default_nettype wire

/* File: testbench/tb.sv */
`timescale 1ns/10ps
`default_nettype none
module tb;
   localparam logic [3:0] OP = usbtr_pkg::PID_OUT;
   localparam logic [3:0] IP = usbtr_pkg::PID_IN;
   localparam logic [3:0] SP = usbtr_pkg::PID_SETUP;
   localparam logic [2:0] A = 3'h0, N = 3'h1, S = 3'h2, Z = 3'h3, D = 3'h4;
   logic clk = 1'b0, arst_n = 1'b0, ce = 1'b1, cmd_valid = 1'b0;
   logic cmd_tog = 1'b0, cmd_corrupt = 1'b0, cmd_iso = 1'b0, cmd_ready;
   logic iso_full, res_valid, res_tog, res_bad, in_valid, tx_ready;
   logic [3:0] cmd_pid = 4'h0, cmd_ep = 4'h0, tx_ep = 4'h0, rx_ep;
   logic [8:0] cmd_len = 9'h000, res_len, n;
   logic [7:0] cmd_seed = 8'h00, tx_data = 8'h00, in_byte, rx_byte;
   logic [2:0] res_code;
   logic tx_valid = 1'b0, tx_last = 1'b0, inj_err = 1'b0, rx_ready = 1'b1;
   logic rx_valid, rx_end, rx_bad, rx_setup;
   logic [15:0] halt = 16'h0000;
   int seed, mismatches, checks_done, nrx, nbad;
   usbtr_link_if lnk ();
   // short frame keeps the iso budget reachable in a short run
   usbtr_host #(.FRAME_CYC(2000)) usbtr_host_i (.*);
   usbtr_device usbtr_device_i (.*);
   usbtr_link_assertions usbtr_link_assertions_i (.clk(clk),
      .arst_n(arst_n), .h_vld(lnk.h_vld), .h_pid(lnk.h_pid),
      .h_ep(lnk.h_ep), .h_end(lnk.h_end), .h_err(lnk.h_err),
      .d_vld(lnk.d_vld), .d_pid(lnk.d_pid), .d_dat(lnk.d_dat),
      .d_end(lnk.d_end), .d_err(lnk.d_err));
   always #2.5 clk = ~clk;
   always @(posedge clk) begin
      if (cmd_ep == 4'h4 && rx_valid === 1'b1) begin
         chk(rx_byte === cmd_seed + 8'(nrx) && rx_ep === 4'h4 &&
             rx_setup === 1'b0);
      end
      nrx += int'(rx_valid === 1'b1);
      nbad += int'(rx_end === 1'b1 && rx_bad === 1'b1);
   end
   task automatic summarize;
      $display("checks %0d mismatches %0d", checks_done, mismatches);
      if (mismatches == 0 && checks_done > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask
   task automatic chk(input logic ok);
      checks_done++;
      if (ok !== 1'b1) begin
         mismatches++;
         $display("CHECK FAILED at %0t: wrong result", $time);
      end
   endtask
   task automatic wait_hi(ref logic s);
      int k;
      k = 0;
      while (s !== 1'b1) begin
         @(negedge clk);
         k++;
         if (k > 999) begin
            chk(1'b0);
            summarize();
         end
      end
   endtask
   // f holds iso, corrupt and toggle, in that order
   task automatic tr(input logic [3:0] p, e, input logic [8:0] l,
                     input logic [2:0] f, x);
      {cmd_pid, cmd_ep, cmd_len} = {p, e, l};
      {cmd_iso, cmd_corrupt, cmd_tog} = f;
      wait_hi(cmd_ready);
      cmd_valid = 1'b1;
      @(negedge clk);
      cmd_valid = 1'b0;
      wait_hi(res_valid);
      chk(res_code === x);
      $display("transaction done, code %0d", res_code);
   endtask
   task automatic push(input logic [3:0] e, input int c);
      tx_ep = e;
      for (int i = 0; i < c; i++) begin
         {tx_data, tx_last, tx_valid} = {8'(i), i == c - 1, 1'b1};
         wait_hi(tx_ready);
         @(negedge clk);
      end
      tx_valid = 1'b0;
      repeat (c + 4) @(negedge clk);
   endtask
   initial begin
      seed = 33661;
      repeat (20) @(negedge clk);
      arst_n = 1'b1;
      @(negedge clk);
      tr(OP, 4'h3, 9'h002, 3'h0, A);
      tr(OP, 4'h3, 9'h002, 3'h0, A);
      chk(nrx === 2);
      rx_ready = 1'b0;
      tr(OP, 4'h3, 9'h002, 3'h1, N);
      rx_ready = 1'b1;
      tr(OP, 4'h3, 9'h002, 3'h3, Z);
      halt = 16'h0008;
      tr(OP, 4'h3, 9'h001, 3'h1, S);
      tr(IP, 4'h3, 9'h000, 3'h0, S);
      halt = 16'h0000;
      tr(IP, 4'h3, 9'h000, 3'h0, N);
      push(4'h3, 3);
      inj_err = 1'b1;
      tr(IP, 4'h3, 9'h000, 3'h0, D);
      chk(res_bad === 1'b1);
      inj_err = 1'b0;
      // device still waits out its handshake timeout
      repeat (310) @(negedge clk);
      tr(IP, 4'h3, 9'h000, 3'h0, D);
      chk(res_tog === 1'b0 && res_len === 9'h003);
      tr(IP, 4'h3, 9'h000, 3'h0, N);
      push(4'h3, 1);
      tr(IP, 4'h3, 9'h000, 3'h0, D);
      chk(res_tog === 1'b1);
      {nrx, nbad} = {32'h0, 32'h0};
      tr(OP, 4'h1, 9'h004, 3'h6, Z);
      repeat (3) @(negedge clk);
      chk(nrx === 4 && nbad === 1);
      tr(IP, 4'h1, 9'h000, 3'h4, D);
      tr(SP, 4'h0, 9'h008, 3'h2, Z);
      tr(SP, 4'h0, 9'h008, 3'h0, A);
      tr(OP, 4'h0, 9'h002, 3'h1, A);
      tr(IP, 4'h0, 9'h000, 3'h0, D);
      chk(res_tog === 1'b1 && res_len === 9'h000);
      cmd_seed = 8'h80;
      tr(SP, 4'h0, 9'h008, 3'h0, A);
      push(4'h0, 2);
      tr(IP, 4'h0, 9'h000, 3'h0, D);
      chk(res_tog === 1'b1 && res_len === 9'h002);
      tr(OP, 4'h0, 9'h000, 3'h1, A);
      tr(SP, 4'h3, 9'h008, 3'h0, Z);
      push(4'h2, 10);
      tr(IP, 4'h2, 9'h000, 3'h0, D);
      chk(res_len === 9'h008 && res_tog === 1'b0);
      repeat (4) @(negedge clk);
      tr(IP, 4'h2, 9'h000, 3'h0, D);
      chk(res_len === 9'h002 && res_tog === 1'b1);
      for (int i = 0; i < 20; i++) begin
         n = 9'(1 + {$random(seed)} % 64);
         cmd_seed = 8'($random(seed));
         nrx = 0;
         tr(OP, 4'h4, n, {2'h0, i[0]}, A);
         chk(nrx === int'(n));
      end
      summarize();
   end
endmodule
`default_nettype wire
